// [include/dsf_defines.svh]
// Constants for the deep synchronous FIFO with programmable flags.
// Assumes inclusion by bare name from files under include/, hw/ and verif/.
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

// ==========================================================
// Geometry
`define DSF_WIDTH 9
`define DSF_ADDR_W 16
`define DSF_CNT_W 17
`define DSF_DEPTH 17'h10000
`define DSF_STAGE_DEPTH 8

// ==========================================================
// Offset register reset values (n = 7, m = 7)
`define DSF_EMPTY_LOW_RST 9'h007
`define DSF_EMPTY_HIGH_RST 9'h000
`define DSF_FULL_LOW_RST 9'h007
`define DSF_FULL_HIGH_RST 9'h000

// ==========================================================
// Pin synchroniser packing and reset levels
`define DSF_PIN_W 14
`define DSF_PIN_RST 14'h3E00

`endif

// [include/dsf_pkg.sv]
// Types shared by the deep synchronous FIFO files.
// Assumes dsf_defines.svh is on the include path.
`include "dsf_defines.svh"

package dsf_pkg;

    // ==========================================================
    // Offset register rotation
    typedef enum logic [1:0] {
        DSF_SEL_EMPTY_LOW = 2'b00,
        DSF_SEL_EMPTY_HIGH = 2'b01,
        DSF_SEL_FULL_LOW = 2'b10,
        DSF_SEL_FULL_HIGH = 2'b11
    } dsf_sel_e;

    typedef logic [`DSF_WIDTH-1:0] dsf_word_t;
    typedef logic [`DSF_CNT_W-1:0] dsf_count_t;
    typedef logic [`DSF_ADDR_W-1:0] dsf_addr_t;

endpackage

// [hw/dsf_pin_sync.sv]
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes each bit is independent; multi-bit words are sampled with the strobe that qualifies them.
`timescale 1ns/10ps
`default_nettype none

module dsf_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // System
    input wire logic clock,
    input wire logic arst_n,
    // Pins
    input wire logic [WIDTH-1:0] din,
    // Synchronised
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    // ==========================================================
    // The first stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

`default_nettype wire

// [hw/dsf_stage_fifo.sv]
// Small staging FIFO with valid/ready on both sides.
// Assumes one clock; clear empties it synchronously.
`timescale 1ns/10ps
`default_nettype none

module dsf_stage_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // System
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clear,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] tail;
    logic [PTR_W:0] level;
    logic push;
    logic pop;

    assign in_ready = (level != PTR_W'(0) + (PTR_W+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (level != '0);
    assign out_data = store[head];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ==========================================================
    // Storage
    always_ff @(posedge clock) begin
        if (push) begin
            store[tail] <= in_data;
        end
    end

    // ==========================================================
    // Pointers and level
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            head <= '0;
            tail <= '0;
            level <= '0;
        end else if (clear) begin
            head <= '0;
            tail <= '0;
            level <= '0;
        end else begin
            if (push) begin
                tail <= (tail == PTR_W'(DEPTH - 1)) ? '0 : tail + 1'b1;
            end
            if (pop) begin
                head <= (head == PTR_W'(DEPTH - 1)) ? '0 : head + 1'b1;
            end
            level <= level + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

endmodule

`default_nettype wire

// [hw/dsf_fifo_top.sv]
// Deep synchronous 9-bit FIFO, 64K words, with empty, full and
// programmable almost-empty / almost-full flags and four offset registers.
// Assumes write and read sides share one clock; all control pins arrive
// asynchronously and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "dsf_defines.svh"

module dsf_fifo_top
    import dsf_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic arst_n,
    // Control pins
    input wire logic fifo_reset_n,
    input wire logic offset_load_n,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic output_en_n,
    // Write data
    input wire logic [`DSF_WIDTH-1:0] write_data,
    // Read data, three-state output
    output logic [`DSF_WIDTH-1:0] read_data,
    output logic read_data_oe,
    // Flags
    output logic empty_flag_n,
    output logic almost_empty_flag_n,
    output logic full_flag_n,
    output logic almost_full_flag_n
);

    // ==========================================================
    // Declarations
    logic [`DSF_PIN_W-1:0] pins_s;
    logic rst_s;
    logic load_s;
    logic wen_s;
    logic ren_s;
    logic oe_s;
    dsf_word_t wdata_s;

    logic standalone;
    logic prog_mode;
    logic wr_ok;
    logic rd_ok;
    logic off_wr;
    logic off_rd;

    logic stg_in_ready;
    logic stg_out_valid;
    dsf_word_t stg_out_data;
    logic drain;

    dsf_word_t mem [2**`DSF_ADDR_W];
    dsf_addr_t wptr;
    dsf_addr_t rptr;
    dsf_count_t total_count;
    dsf_count_t main_count;
    dsf_count_t next_total_count;
    dsf_count_t next_main_count;

    dsf_word_t offset_reg [4];
    dsf_sel_e sel;
    logic [17:0] empty_offset;
    logic [17:0] full_offset;
    logic [18:0] full_sum;
    logic almost_full_int;

    // ==========================================================
    // Rotation to the next offset register
    function automatic dsf_sel_e next_sel(input dsf_sel_e cur);
        case (cur)
            DSF_SEL_EMPTY_LOW: next_sel = DSF_SEL_EMPTY_HIGH;
            DSF_SEL_EMPTY_HIGH: next_sel = DSF_SEL_FULL_LOW;
            DSF_SEL_FULL_LOW: next_sel = DSF_SEL_FULL_HIGH;
            DSF_SEL_FULL_HIGH: next_sel = DSF_SEL_EMPTY_LOW;
            default: next_sel = DSF_SEL_EMPTY_LOW;
        endcase
    endfunction

    // ==========================================================
    // Pin synchronisers
    dsf_pin_sync #(
        .WIDTH(`DSF_PIN_W),
        .RESET_VAL(`DSF_PIN_RST)
    ) u_pin_sync (
        .clock(clock),
        .arst_n(arst_n),
        .din({fifo_reset_n, offset_load_n, write_en_n, read_en_n, output_en_n, write_data}),
        .dout(pins_s)
    );

    // Data rides the same two stages as the enables, so they stay aligned
    assign rst_s = pins_s[13];
    assign load_s = pins_s[12];
    assign wen_s = pins_s[11];
    assign ren_s = pins_s[10];
    assign oe_s = pins_s[9];
    assign wdata_s = pins_s[8:0];

    // ==========================================================
    // Configuration strap, caught while the FIFO reset is low
    // Load low through reset keeps offset access; high means a cascade neighbour drives it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            standalone <= 1'b1;
        end else if (!rst_s) begin
            standalone <= !load_s;
        end
    end

    // Token passing for depth expansion is not built; that mode runs as plain FIFO
    assign prog_mode = standalone && !load_s;

    // ==========================================================
    // Access qualification; nothing is accepted during reset
    assign wr_ok = rst_s && !prog_mode && !wen_s && full_flag_n && stg_in_ready;
    assign rd_ok = rst_s && !prog_mode && !ren_s && empty_flag_n;
    assign off_wr = rst_s && prog_mode && !wen_s;
    // A simultaneous offset write takes precedence so the rotation steps once
    assign off_rd = rst_s && prog_mode && !ren_s && !off_wr;

    // ==========================================================
    // Staging buffer between the write pins and the deep array
    dsf_stage_fifo #(
        .WIDTH(`DSF_WIDTH),
        .DEPTH(`DSF_STAGE_DEPTH)
    ) u_stage (
        .clock(clock),
        .arst_n(arst_n),
        .clear(!rst_s),
        .in_valid(wr_ok),
        .in_ready(stg_in_ready),
        .in_data(wdata_s),
        .out_valid(stg_out_valid),
        .out_ready(drain),
        .out_data(stg_out_data)
    );

    // Drains one word a cycle while the array has room
    // Full counts staged words as well, so the array can never be overrun
    assign drain = stg_out_valid && (main_count != `DSF_DEPTH);

    // ==========================================================
    // Deep array
    always_ff @(posedge clock) begin
        if (drain) begin
            mem[wptr] <= stg_out_data;
        end
    end

    // ==========================================================
    // Pointers, wrapping naturally at the array depth
    // Wrap comes from overflow because the depth is a power of two
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wptr <= '0;
            rptr <= '0;
        end else if (!rst_s) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (drain) begin
                wptr <= wptr + 1'b1;
            end
            if (rd_ok) begin
                rptr <= rptr + 1'b1;
            end
        end
    end

    // ==========================================================
    // Word counts: total includes staged words, main only readable ones
    // Staged words are not yet readable, so the empty side lags a write by one cycle
    always_comb begin
        next_total_count = total_count + `DSF_CNT_W'(wr_ok) - `DSF_CNT_W'(rd_ok);
        next_main_count = main_count + `DSF_CNT_W'(drain) - `DSF_CNT_W'(rd_ok);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            total_count <= '0;
            main_count <= '0;
        end else if (!rst_s) begin
            total_count <= '0;
            main_count <= '0;
        end else begin
            total_count <= next_total_count;
            main_count <= next_main_count;
        end
    end

    // ==========================================================
    // Offset registers and rotation position
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            offset_reg[0] <= `DSF_EMPTY_LOW_RST;
            offset_reg[1] <= `DSF_EMPTY_HIGH_RST;
            offset_reg[2] <= `DSF_FULL_LOW_RST;
            offset_reg[3] <= `DSF_FULL_HIGH_RST;
        end else if (!rst_s) begin
            offset_reg[0] <= `DSF_EMPTY_LOW_RST;
            offset_reg[1] <= `DSF_EMPTY_HIGH_RST;
            offset_reg[2] <= `DSF_FULL_LOW_RST;
            offset_reg[3] <= `DSF_FULL_HIGH_RST;
        end else if (off_wr) begin
            offset_reg[sel] <= wdata_s;
        end
    end

    // Position survives leaving program mode
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sel <= DSF_SEL_EMPTY_LOW;
        end else if (!rst_s) begin
            sel <= DSF_SEL_EMPTY_LOW;
        end else if (off_wr || off_rd) begin
            sel <= next_sel(sel);
        end
    end

    assign empty_offset = {offset_reg[1], offset_reg[0]};
    assign full_offset = {offset_reg[3], offset_reg[2]};
    // Adding m to the count avoids a subtraction that could wrap below zero
    assign full_sum = {2'b00, next_total_count} + {1'b0, full_offset};

    // ==========================================================
    // Output register; a blocked read leaves it untouched
    // Program mode blocks normal reads, so the two loads never meet
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            read_data <= '0;
        end else if (!rst_s) begin
            read_data <= '0;
        end else if (rd_ok) begin
            read_data <= mem[rptr];
        end else if (off_rd) begin
            read_data <= offset_reg[sel];
        end
    end

    // The pad buffer sits outside; only its enable is made here
    assign read_data_oe = !oe_s;

    // ==========================================================
    // Empty side flags, from the readable count
    // Next count is used so a read shows on the flags in the same edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            empty_flag_n <= 1'b0;
            almost_empty_flag_n <= 1'b0;
        end else if (!rst_s) begin
            empty_flag_n <= 1'b0;
            almost_empty_flag_n <= 1'b0;
        end else begin
            empty_flag_n <= (next_main_count != '0);
            almost_empty_flag_n <= ({1'b0, next_main_count} > empty_offset);
        end
    end

    // ==========================================================
    // Full side flags, from the count including staged words
    // Counting staged words stops the writer before the staging buffer overflows
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            full_flag_n <= 1'b1;
            almost_full_int <= 1'b1;
        end else if (!rst_s) begin
            full_flag_n <= 1'b1;
            almost_full_int <= 1'b1;
        end else begin
            full_flag_n <= (next_total_count != `DSF_DEPTH);
            almost_full_int <= (full_sum < {2'b00, `DSF_DEPTH});
        end
    end

    // Cascade output is not built; that pin idles high in depth mode
    assign almost_full_flag_n = standalone ? almost_full_int : 1'b1;

endmodule

`default_nettype wire

// [verif/dsf_fifo_checker.sv]
// Checker for the deep FIFO top: flag, data and output enable relations.
// Assumes one clock for both sides and pins that pass two sync flops.
`timescale 1ns/10ps
`default_nettype none
`include "dsf_defines.svh"

module dsf_fifo_checker (
    // System
    input wire logic clock,
    input wire logic arst_n,
    // Control pins
    input wire logic fifo_reset_n,
    input wire logic offset_load_n,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic output_en_n,
    input wire logic [`DSF_WIDTH-1:0] write_data,
    // Outputs
    input wire logic [`DSF_WIDTH-1:0] read_data,
    input wire logic read_data_oe,
    input wire logic empty_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic full_flag_n,
    input wire logic almost_full_flag_n
);
    // ==========================================================
    // Ages since the last request; saturate so they never wrap
    logic [3:0] wr_age;
    logic [3:0] rd_age;
    logic [3:0] rs_age;
    logic [3:0] quiet;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_age <= 4'hF;
            rd_age <= 4'hF;
            rs_age <= 4'h0;
            quiet <= 4'h0;
        end else begin
            wr_age <= !write_en_n ? 4'h0 : (wr_age == 4'hF ? wr_age : wr_age + 4'h1);
            rd_age <= !read_en_n ? 4'h0 : (rd_age == 4'hF ? rd_age : rd_age + 4'h1);
            rs_age <= !fifo_reset_n ? 4'h0 : (rs_age == 4'hF ? rs_age : rs_age + 4'h1);
            quiet <= !(offset_load_n && fifo_reset_n) ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_FLAGS_EXCLUSIVE: assert property (!(!empty_flag_n && !full_flag_n))
        else $error("empty and full flags low together");
    AST_EMPTY_HAS_AE: assert property (!empty_flag_n |-> !almost_empty_flag_n)
        else $error("almost empty high while empty");
    AST_OE_TRACKS: assert property (read_data_oe == !$past(output_en_n, 2))
        else $error("output enable does not follow its pin");
    AST_FRESET: assert property (!fifo_reset_n [*3] |=> (!empty_flag_n && !almost_empty_flag_n
        && full_flag_n && almost_full_flag_n && read_data == '0))
        else $error("fifo reset did not clear flags and data");
    AST_KEEP_LAST: assert property (quiet >= 4'h4 && $past(!empty_flag_n) |-> $stable(read_data))
        else $error("read data changed while empty");
    AST_EMPTY_RISE: assert property ($rose(empty_flag_n) |-> wr_age <= 4'hC)
        else $error("empty flag rose without a write");
    AST_EMPTY_FALL: assert property ($fell(empty_flag_n) |-> (rd_age <= 4'hC || rs_age <= 4'hC))
        else $error("empty flag fell without a read");
    AST_FULL_FALL: assert property ($fell(full_flag_n) |-> wr_age <= 4'hC)
        else $error("full flag fell without a write");
    AST_FULL_RISE: assert property ($rose(full_flag_n) |-> (rd_age <= 4'hC || rs_age <= 4'hC))
        else $error("full flag rose without a read");
    AST_AE_RISE: assert property ($rose(almost_empty_flag_n) |-> wr_age <= 4'hC)
        else $error("almost empty rose without a write");
    AST_AF_FALL: assert property ($fell(almost_full_flag_n) |-> wr_age <= 4'hC)
        else $error("almost full fell without a write");
endmodule

bind dsf_fifo_top dsf_fifo_checker chk_u (.clock(clock), .arst_n(arst_n), .fifo_reset_n(fifo_reset_n),
    .offset_load_n(offset_load_n), .write_en_n(write_en_n), .read_en_n(read_en_n),
    .output_en_n(output_en_n), .write_data(write_data), .read_data(read_data),
    .read_data_oe(read_data_oe), .empty_flag_n(empty_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
    .full_flag_n(full_flag_n), .almost_full_flag_n(almost_full_flag_n));

`default_nettype wire

// [verif/dsf_bus_model.sv]
// Reader-side data bus as the far logic sees it.
// Assumes no pull on the bus, so a released bus shows the inverse of its last level.
`timescale 1ns/10ps
`default_nettype none
`include "dsf_defines.svh"

module dsf_bus_model (
    // System
    input wire logic clock,
    // Device pins
    input wire logic [`DSF_WIDTH-1:0] read_data,
    input wire logic read_data_oe,
    // Bus seen by the reader
    output logic [`DSF_WIDTH-1:0] bus_level
);
    // ==========================================================
    // Released bus must not look like valid data
    logic [`DSF_WIDTH-1:0] last;

    always_ff @(posedge clock) begin
        if (read_data_oe) begin
            last <= read_data;
        end
    end

    assign bus_level = read_data_oe ? read_data : ~last;
endmodule

`default_nettype wire

// [verif/dsf_fifo_top_bench.sv]
// Bench for the deep FIFO top: offsets, streaming, flags, three-state output.
// Assumes pins act two sync edges after sampling; runs about 66k cycles.
`timescale 1ns/10ps
`default_nettype none
`include "dsf_defines.svh"

module dsf_fifo_top_bench;
    // ==========================================================
    // Pins and counters
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic fifo_reset_n = 1'b0;
    logic offset_load_n = 1'b0;
    logic write_en_n = 1'b1;
    logic read_en_n = 1'b1;
    logic output_en_n = 1'b1;
    logic [8:0] write_data = 9'h000;
    logic [8:0] read_data;
    logic [8:0] bus_level;
    logic read_data_oe, empty_flag_n, almost_empty_flag_n, full_flag_n, almost_full_flag_n;
    int bad_count = 0;
    int checks = 0;

    always #25 clock = ~clock;

    dsf_fifo_top dut_u (.clock(clock), .arst_n(arst_n), .fifo_reset_n(fifo_reset_n),
        .offset_load_n(offset_load_n), .write_en_n(write_en_n), .read_en_n(read_en_n),
        .output_en_n(output_en_n), .write_data(write_data), .read_data(read_data),
        .read_data_oe(read_data_oe), .empty_flag_n(empty_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
        .full_flag_n(full_flag_n), .almost_full_flag_n(almost_full_flag_n));
    dsf_bus_model bus_u (.clock(clock), .read_data(read_data), .read_data_oe(read_data_oe),
        .bus_level(bus_level));

    // ==========================================================
    // Shared tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // Order: empty, almost empty, full, almost full
    task automatic flg(input logic [3:0] e);
        check({5'h00, empty_flag_n, almost_empty_flag_n, full_flag_n, almost_full_flag_n}, {5'h00, e}, "flags");
    endtask

    // One sampled pin edge, then settle; never writes and reads offsets together
    task automatic op(input logic ld, input logic w, input logic r, input logic [8:0] d);
        @(posedge clock);
        offset_load_n <= ld;
        write_en_n <= w;
        read_en_n <= r;
        write_data <= d;
        @(posedge clock);
        write_en_n <= 1'b1;
        read_en_n <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
    endtask

    task automatic hold_write(input int n, input logic [8:0] d);
        @(posedge clock);
        offset_load_n <= 1'b1;
        write_en_n <= 1'b0;
        write_data <= d;
        repeat (n) @(posedge clock);
        write_en_n <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
    endtask

    // Load level through reset picks standalone (low) or depth mode; no access meanwhile
    task automatic freset(input logic ld);
        @(posedge clock);
        fifo_reset_n <= 1'b0;
        offset_load_n <= ld;
        repeat (4) @(posedge clock);
        fifo_reset_n <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_offsets();
        logic [8:0] v[4];
        flg(4'b0011);
        check(read_data, 9'h000, "data after reset");
        v = '{9'h007, 9'h000, 9'h007, 9'h000};
        for (int i = 0; i < 4; i++) begin
            op(1'b0, 1'b1, 1'b0, 9'h000);
            check(read_data, v[i], "default offset");
        end
        v = '{9'h002, 9'h000, 9'h007, 9'h000};
        op(1'b0, 1'b0, 1'b1, v[0]);
        op(1'b1, 1'b1, 1'b1, 9'h000);
        for (int i = 1; i < 4; i++) op(1'b0, 1'b0, 1'b1, v[i]);
        for (int i = 0; i < 4; i++) begin
            op(1'b0, 1'b1, 1'b0, 9'h000);
            check(read_data, v[i], "offset readback");
        end
        $display("test offsets done");
    endtask

    task automatic t_stream();
        logic [8:0] d[3];
        logic [3:0] fw[3];
        logic [3:0] fr[3];
        d = '{9'h101, 9'h0F2, 9'h1A3};
        fw = '{4'b1011, 4'b1011, 4'b1111};
        fr = '{4'b1011, 4'b1011, 4'b0011};
        for (int i = 0; i < 3; i++) begin
            op(1'b1, 1'b0, 1'b1, d[i]);
            flg(fw[i]);
        end
        for (int i = 0; i < 3; i++) begin
            op(1'b1, 1'b1, 1'b0, 9'h000);
            check(read_data, d[i], "read word");
            flg(fr[i]);
        end
        op(1'b1, 1'b1, 1'b0, 9'h000);
        check(read_data, d[2], "last word kept");
        flg(4'b0011);
        $display("test stream done");
    endtask

    task automatic t_oe();
        @(posedge clock);
        output_en_n <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check({8'h00, read_data_oe}, 9'h001, "oe on");
        check(bus_level, read_data, "bus driven");
        @(posedge clock);
        output_en_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check({8'h00, read_data_oe}, 9'h000, "oe off");
        check(bus_level, ~read_data, "bus released");
        $display("test output enable done");
    endtask

    task automatic t_full();
        freset(1'b0);
        flg(4'b0011);
        hold_write(1, 9'h1C3);
        hold_write(65527, 9'h05A);
        flg(4'b1111);
        hold_write(1, 9'h05A);
        flg(4'b1110);
        hold_write(6, 9'h05A);
        flg(4'b1110);
        hold_write(1, 9'h05A);
        flg(4'b1100);
        hold_write(1, 9'h1FF);
        flg(4'b1100);
        op(1'b1, 1'b1, 1'b0, 9'h000);
        check(read_data, 9'h1C3, "first word");
        flg(4'b1110);
        hold_write(1, 9'h05A);
        flg(4'b1100);
        freset(1'b0);
        flg(4'b0011);
        check(read_data, 9'h000, "data after fifo reset");
        $display("test full done");
    endtask

    // Load high through reset picks depth mode: load low then writes data, not offsets
    task automatic t_depth();
        freset(1'b1);
        flg(4'b0011);
        op(1'b0, 1'b0, 1'b1, 9'h0A5);
        flg(4'b1011);
        op(1'b0, 1'b1, 1'b0, 9'h000);
        check(read_data, 9'h0A5, "depth mode word");
        flg(4'b0011);
        freset(1'b0);
        flg(4'b0011);
        $display("test depth mode done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        fifo_reset_n <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        t_offsets();
        t_stream();
        t_oe();
        t_full();
        t_depth();
        report_and_stop();
    end

    initial begin
        repeat (90000) @(posedge clock);
        bad_count++;
        $display("[ERR] %0t run timed out", $time);
        report_and_stop();
    end
endmodule

`default_nettype wire
